/* File: rtl/fwp_pkg.sv */
package fwp_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  // write lockout after supply comes good, plain default
  localparam int PUW_TIME_US = 1000;
  localparam int PUW_CYCLES = (PUW_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // stand-in duration of an internal program, erase or status write
  localparam int OP_TIME_NS = 256;
  localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 21;
  localparam int BIT_CNT_W = 12;
  localparam logic [ADDR_W-1:0] ARRAY_TOP = 21'h1FFFFF;
  localparam logic [4:0] ARRAY_LOG = 5'h15;
  localparam logic [4:0] BLOCK_LOG = 5'h10;
  localparam logic [4:0] SECTOR_LOG = 5'h0C;
  localparam logic [4:0] SEC_CAP_LOG = 5'h0F;
  localparam logic [4:0] PAGE_LOG = 5'h08;
  localparam logic [2:0] EXT_NONE = 3'h0;
  localparam logic [2:0] EXT_FULL_MIN = 3'h6;
  localparam logic [2:0] EXT_SEC_CAP = 3'h4;

  // ---------------------------------------------------------------
  // command codes and lengths in bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_SECT = 8'h20;
  localparam logic [7:0] OP_BLOCK = 8'hD8;
  localparam logic [7:0] OP_CHIP_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_B = 8'h60;
  localparam logic [7:0] OP_WSR1 = 8'h01;
  localparam logic [7:0] OP_WSR2 = 8'h31;
  localparam logic [7:0] OP_WSR3 = 8'h11;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;
  localparam logic [8:0] LEN_CMD = 9'h001;
  localparam logic [8:0] LEN_ONE_DATA = 9'h002;
  localparam logic [8:0] LEN_TWO_DATA = 9'h003;
  localparam logic [8:0] LEN_ADDR = 9'h004;
  localparam logic [8:0] LEN_PROG_MIN = 9'h005;

  // ---------------------------------------------------------------
  // status register layout
  // ---------------------------------------------------------------
  localparam int SR1_BUSY = 0;
  localparam int SR1_WEL = 1;
  localparam int SR1_EXT_LSB = 2;
  localparam int SR1_BOTTOM = 5;
  localparam int SR1_SEC = 6;
  localparam int SR1_LOCK = 7;
  localparam int SR2_QE = 1;
  localparam int SR2_CMP = 6;
  localparam int SR3_HFQ = 4;
  localparam int SR3_DRV_LSB = 5;
  localparam int SR3_PIN_FUNCTION_SELECT = 7;
  localparam logic [7:0] SR1_WR_MASK = 8'hFC;
  localparam logic [7:0] SR2_WR_MASK = 8'h42;
  localparam logic [7:0] SR3_WR_MASK = 8'hF0;
  localparam logic [7:0] SR_RESET = 8'h00;

  // drive strength in percent per code
  localparam logic [6:0] DRV_PCT_00 = 7'h32;
  localparam logic [6:0] DRV_PCT_01 = 7'h19;
  localparam logic [6:0] DRV_PCT_10 = 7'h4B;
  localparam logic [6:0] DRV_PCT_11 = 7'h64;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sclk;
    logic csN;
    logic dataIn;
    logic guardN;
    logic mfPin;
    logic supplyLow;
  } fwp_pins_type;

  localparam fwp_pins_type PINS_IDLE = 6'h1F;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] first;
    logic [ADDR_W-1:0] last;
  } fwp_range_type;

  typedef enum logic [1:0] {ST_OFF, ST_READY, ST_BUSY, ST_SLEEP} fwp_state_type;

endpackage

/* File: rtl/fwp_sync.sv */
`timescale 1ns/1ps
module fwp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage1_reg <= RST_VAL;
      syncOut <= RST_VAL;
    end else begin
      stage1_reg <= asyncIn;
      syncOut <= stage1_reg;
    end
  end

endmodule

/* File: rtl/fwp_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - quad off: pin pauses or resets per select
// - quad on: pin is data only
// - drive code maps to 50/25/75/100 percent
// - high frequency quad mode follows its bit
// - write commands need whole bytes at deselect
// - low supply disables all commands and clears the latch
// - write commands refused during power-up lockout
// - write latch cleared at power-up
// - program, erase, status write need latch set
// - latch clears when operation completes
// - deep sleep ignores all but wake
// - protection bits set by status write
// - guard pin with lock mode gates status writes while quad is off
// - top protection in 64 KB blocks
// - bottom protection in 64 KB blocks
// - code 000 none, 11x whole array
// - top protection in 4 KB sectors
// - bottom protection in 4 KB sectors
// - invert bit swaps protected and free
// - command touching protected address ignored
// - lock mode and guard low lock status while quad is off
// - extent bits 4:2, bottom 5, sector 6
module fwp_ctrl
  import fwp_pkg::*;
#(
  parameter int PUW_COUNT = PUW_CYCLES,
  parameter int OP_COUNT = OP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic spiClk,
  input wire logic chipSelN,
  input wire logic serialDataIn,
  input wire logic writeGuardN,
  input wire logic mfPinIn,
  input wire logic supplyLow,
  output logic pauseActive,
  output logic pinResetActive,
  output logic mfPinIsData,
  output logic [6:0] driveStrengthPct,
  output logic highFreqQuad,
  output logic writeEnableLatch,
  output logic deviceBusy,
  output logic deepSleep,
  output logic writeLockout,
  output logic [7:0] statusRegOne,
  output logic [7:0] statusRegTwo,
  output logic [7:0] statusRegThree,
  output fwp_pkg::fwp_range_type protRange,
  output logic opStart,
  output logic [7:0] opCode,
  output fwp_pkg::fwp_range_type opTarget,
  output logic cmdRejected
);

  import fwp_pkg::*;

  localparam int PUW_W = $clog2(PUW_COUNT + 1);
  localparam int OP_W = $clog2(OP_COUNT + 1);

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  fwp_pins_type pinsRaw;
  fwp_pins_type pinsSync;
  logic sclkPrev_reg;
  logic csPrev_reg;

  assign pinsRaw = '{spiClk, chipSelN, serialDataIn, writeGuardN, mfPinIn, supplyLow};

  fwp_sync #(
    .WIDTH($bits(fwp_pins_type)),
    .RST_VAL(PINS_IDLE)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .asyncIn(pinsRaw),
    .syncOut(pinsSync)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sclkPrev_reg <= 1'b0;
      csPrev_reg <= 1'b1;
    end else begin
      sclkPrev_reg <= pinsSync.sclk;
      csPrev_reg <= pinsSync.csN;
    end
  end

  wire sclkRise = pinsSync.sclk & ~sclkPrev_reg;
  wire csRise = pinsSync.csN & ~csPrev_reg;
  wire csFall = ~pinsSync.csN & csPrev_reg;

  // ---------------------------------------------------------------
  // status registers and pin function
  // ---------------------------------------------------------------
  logic [7:0] sr1_reg;
  logic [7:0] sr2_reg;
  logic [7:0] sr3_reg;
  fwp_state_type state_reg;
  fwp_state_type state_next;

  wire [2:0] extent = sr1_reg[SR1_EXT_LSB +: 3];
  wire bottomSel = sr1_reg[SR1_BOTTOM];
  wire sectorGran = sr1_reg[SR1_SEC];
  wire lockMode = sr1_reg[SR1_LOCK];
  wire quadIo = sr2_reg[SR2_QE];
  wire invertProt = sr2_reg[SR2_CMP];
  wire pinFuncSel = sr3_reg[SR3_PIN_FUNCTION_SELECT];
  wire [1:0] drvSel = sr3_reg[SR3_DRV_LSB +: 2];

  wire pauseNow = ~quadIo & ~pinFuncSel & ~pinsSync.mfPin;
  wire pinResetNow = ~quadIo & pinFuncSel & ~pinsSync.mfPin;
  wire powerOff = pinsSync.supplyLow;

  wire [6:0] drvPct = drvSel == 2'h0 ? DRV_PCT_00 :
                      drvSel == 2'h1 ? DRV_PCT_01 :
                      drvSel == 2'h2 ? DRV_PCT_10 : DRV_PCT_11;

  // ---------------------------------------------------------------
  // serial shifter
  // ---------------------------------------------------------------
  logic [BIT_CNT_W-1:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] opcode_reg;
  logic [23:0] addr_reg;
  logic [7:0] data1_reg;
  logic [7:0] data2_reg;

  // pause freezes the shifter; the host must hold the clock steady meanwhile
  wire shiftEn = sclkRise & ~pinsSync.csN & ~pauseNow & ~pinResetNow & (state_reg != ST_OFF);
  wire byteDone = shiftEn & (bitCnt_reg[2:0] == 3'h7);
  wire [8:0] byteIdx = bitCnt_reg[BIT_CNT_W-1:3];
  wire [7:0] byteNext = {shift_reg[6:0], pinsSync.dataIn};
  wire bitSat = &bitCnt_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || csFall || pinResetNow) begin
      bitCnt_reg <= '0;
    end else if (shiftEn && !bitSat) begin
      bitCnt_reg <= bitCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || csFall) begin
      shift_reg <= 8'h00;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h000000;
      data1_reg <= 8'h00;
      data2_reg <= 8'h00;
    end else if (shiftEn) begin
      shift_reg <= byteNext;
      if (byteDone && byteIdx == 9'h000) opcode_reg <= byteNext;
      if (byteDone && byteIdx == 9'h001) data1_reg <= byteNext;
      if (byteDone && byteIdx == 9'h002) data2_reg <= byteNext;
      if (byteDone && byteIdx >= 9'h001 && byteIdx <= 9'h003) begin
        addr_reg <= {addr_reg[15:0], byteNext};
      end
    end
  end

  // ---------------------------------------------------------------
  // command classification at deselect
  // ---------------------------------------------------------------
  wire [8:0] byteCnt = bitCnt_reg[BIT_CNT_W-1:3];
  wire aligned = (bitCnt_reg[2:0] == 3'h0) & ~bitSat;
  wire isWren = opcode_reg == OP_WREN && byteCnt == LEN_CMD;
  wire isWrdi = opcode_reg == OP_WRDI && byteCnt == LEN_CMD;
  wire isProg = opcode_reg == OP_PROG && byteCnt >= LEN_PROG_MIN;
  wire isSect = opcode_reg == OP_SECT && byteCnt == LEN_ADDR;
  wire isBlock = opcode_reg == OP_BLOCK && byteCnt == LEN_ADDR;
  wire isChip = (opcode_reg == OP_CHIP_A || opcode_reg == OP_CHIP_B) && byteCnt == LEN_CMD;
  wire isWsr1 = opcode_reg == OP_WSR1 && (byteCnt == LEN_ONE_DATA || byteCnt == LEN_TWO_DATA);
  wire isWsr2 = opcode_reg == OP_WSR2 && byteCnt == LEN_ONE_DATA;
  wire isWsr3 = opcode_reg == OP_WSR3 && byteCnt == LEN_ONE_DATA;
  wire isWsr = isWsr1 | isWsr2 | isWsr3;
  wire isSleep = opcode_reg == OP_SLEEP && byteCnt == LEN_CMD;
  wire isWake = opcode_reg == OP_WAKE && byteCnt >= LEN_CMD;
  wire isArray = isProg | isSect | isBlock | isChip;
  wire isWriteClass = isArray | isWsr | isWren;

  // ---------------------------------------------------------------
  // protected range decode
  // ---------------------------------------------------------------
  // field positions
  // sector granularity capped at 32 KB
  wire [4:0] regionLog = extent >= EXT_FULL_MIN ? ARRAY_LOG :
                         !sectorGran ? BLOCK_LOG - 5'h01 + {2'h0, extent} :
                         extent >= EXT_SEC_CAP ? SEC_CAP_LOG :
                         SECTOR_LOG - 5'h01 + {2'h0, extent};
  wire [ADDR_W:0] regionSpan = (22'h000001 << regionLog) - 22'h000001;
  wire [ADDR_W-1:0] regionMask = regionSpan[ADDR_W-1:0];
  wire regionValid = extent != EXT_NONE;
  wire [ADDR_W-1:0] regionFirst = bottomSel ? '0 : ARRAY_TOP & ~regionMask;
  wire [ADDR_W-1:0] regionLast = bottomSel ? regionMask : ARRAY_TOP;

  // whole target span of the command
  wire [4:0] targetLog = isProg ? PAGE_LOG : isSect ? SECTOR_LOG :
                         isBlock ? BLOCK_LOG : ARRAY_LOG;
  wire [ADDR_W:0] targetSpan = (22'h000001 << targetLog) - 22'h000001;
  wire [ADDR_W-1:0] targetMask = targetSpan[ADDR_W-1:0];
  wire [ADDR_W-1:0] targetFirst = addr_reg[ADDR_W-1:0] & ~targetMask;
  wire [ADDR_W-1:0] targetLast = addr_reg[ADDR_W-1:0] | targetMask;

  wire targetInside = regionValid && targetFirst >= regionFirst && targetLast <= regionLast;
  wire targetOverlap = regionValid && targetFirst <= regionLast && targetLast >= regionFirst;
  // any protected byte blocks the command
  wire protHit = invertProt ? ~targetInside : targetOverlap;

  // hardware lock; guard pin is data when quad is on
  wire statusLocked = lockMode & ~pinsSync.guardN & ~quadIo;

  // ---------------------------------------------------------------
  // acceptance
  // ---------------------------------------------------------------
  logic wel_reg;
  logic [PUW_W-1:0] puwCnt_reg;
  logic [OP_W-1:0] opCnt_reg;

  wire puwDone = puwCnt_reg == PUW_W'(PUW_COUNT);
  wire cmdWindow = csRise & (state_reg == ST_READY) & ~pinResetNow;
  // latch and lockout gate write commands
  wire startArray = cmdWindow & isArray & wel_reg & puwDone & aligned & ~protHit;
  // protection bits land only via status write
  wire startWsr = cmdWindow & isWsr & wel_reg & puwDone & aligned & ~statusLocked;
  wire setWel = cmdWindow & isWren & puwDone & aligned;
  wire clrWel = cmdWindow & isWrdi;
  wire enterSleep = cmdWindow & isSleep & aligned;
  wire wakeUp = csRise & (state_reg == ST_SLEEP) & isWake;
  wire refuse = cmdWindow & isWriteClass & ~(startArray | startWsr | setWel);
  wire opDone = (state_reg == ST_BUSY) && opCnt_reg == '0;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        state_next = ST_READY;
      end
      ST_READY: begin
        if (startArray || startWsr) begin
          state_next = ST_BUSY;
        end else if (enterSleep) begin
          state_next = ST_SLEEP;
        end
      end
      ST_BUSY: begin
        if (opDone) state_next = ST_READY;
      end
      ST_SLEEP: begin
        if (wakeUp) state_next = ST_READY;
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    // low supply holds the device off
    if (powerOff) begin
      state_next = ST_OFF;
    end else if (pinResetNow) begin
      state_next = ST_READY;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // lockout timer restarts whenever supply dips
  always_ff @(posedge ref_clk) begin
    if (sys_rst || powerOff) begin
      puwCnt_reg <= '0;
    end else if (!puwDone) begin
      puwCnt_reg <= puwCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      opCnt_reg <= '0;
    end else if (startArray || startWsr) begin
      opCnt_reg <= OP_W'(OP_COUNT - 1);
    end else if (opCnt_reg != '0) begin
      opCnt_reg <= opCnt_reg - 1'b1;
    end
  end

  // latch cleared at power-up and on completion
  always_ff @(posedge ref_clk) begin
    if (sys_rst || powerOff || pinResetNow || opDone || clrWel) begin
      wel_reg <= 1'b0;
    end else if (setWel) begin
      wel_reg <= 1'b1;
    end
  end

  // status write; read-only bits never change
  wire wr1 = startWsr & isWsr1;
  wire wr2 = startWsr & ((isWsr1 & byteCnt == LEN_TWO_DATA) | isWsr2);
  wire wr3 = startWsr & isWsr3;
  wire [7:0] wr2Data = isWsr2 ? data1_reg : data2_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sr1_reg <= SR_RESET;
      sr2_reg <= SR_RESET;
      sr3_reg <= SR_RESET;
    end else begin
      if (wr1) sr1_reg <= data1_reg & SR1_WR_MASK;
      if (wr2) sr2_reg <= wr2Data & SR2_WR_MASK;
      if (wr3) sr3_reg <= data1_reg & SR3_WR_MASK;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  assign writeEnableLatch = wel_reg;
  assign mfPinIsData = quadIo;
  // high frequency flag, zero by default
  assign highFreqQuad = sr3_reg[SR3_HFQ];
  assign statusRegTwo = sr2_reg;
  assign statusRegThree = sr3_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pauseActive <= 1'b0;
      pinResetActive <= 1'b0;
      driveStrengthPct <= DRV_PCT_00;
      deviceBusy <= 1'b0;
      deepSleep <= 1'b0;
      writeLockout <= 1'b1;
      statusRegOne <= SR_RESET;
      protRange <= '0;
      opStart <= 1'b0;
      opCode <= 8'h00;
      opTarget <= '0;
      cmdRejected <= 1'b0;
    end else begin
      pauseActive <= pauseNow;
      pinResetActive <= pinResetNow;
      driveStrengthPct <= drvPct;
      deviceBusy <= state_next == ST_BUSY;
      deepSleep <= state_next == ST_SLEEP;
      writeLockout <= ~puwDone;
      statusRegOne <= {sr1_reg[7:2], wel_reg, state_reg == ST_BUSY};
      protRange <= '{regionValid, regionFirst, regionLast};
      opStart <= startArray;
      cmdRejected <= refuse;
      if (startArray) begin
        opCode <= opcode_reg;
        opTarget <= '{1'b1, targetFirst, targetLast};
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  supply_clears_wel_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    powerOff |=> !wel_reg && state_reg == ST_OFF)
    else $error("write latch or state survived low supply");

  lockout_blocks_op_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    opStart |-> $past(puwDone) && !$past(powerOff))
    else $error("operation started during power-up lockout");

  op_needs_wel_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    opStart |-> $past(wel_reg) && deviceBusy)
    else $error("operation started without write latch");

  done_clears_wel_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    opDone && !powerOff |=> !wel_reg && state_reg == ST_READY)
    else $error("write latch not cleared on completion");

  sleep_ignores_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_reg == ST_SLEEP && !wakeUp && !powerOff && !pinResetNow
      |=> state_reg == ST_SLEEP && !opStart && !deviceBusy)
    else $error("command acted on in deep sleep");

  byte_boundary_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    opStart |-> $past(bitCnt_reg[2:0]) == 3'h0)
    else $error("operation started off a byte boundary");

  prot_blocks_op_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cmdWindow && isArray && protHit |=> !opStart && !deviceBusy)
    else $error("protected range was written");

  status_lock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    statusLocked |=> $stable(sr1_reg) && $stable(sr2_reg))
    else $error("status register changed while locked");

  whole_array_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    extent >= EXT_FULL_MIN |-> regionFirst == '0 && regionLast == ARRAY_TOP)
    else $error("whole-array code decoded wrongly");

  sector_cap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sectorGran && extent >= EXT_SEC_CAP && extent < EXT_FULL_MIN
      |-> regionMask == 21'h007FFF)
    else $error("sector extent not capped at 32 KB");

endmodule

/* File: test/fwp_host.sv */
`timescale 1ns/1ps
module fwp_host (
  input wire logic ref_clk,
  output logic spiClk,
  output logic chipSelN,
  output logic serialDataIn
);
  // ----------------------------------------------------------
  // host side of the link, 32 ns clock that runs only in frames
  // ----------------------------------------------------------
  initial begin
    spiClk = 1'h0;
    chipSelN = 1'h1;
    serialDataIn = 1'h1;
  end
  task automatic half();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  // bits go out msb first from the top of the word
  task automatic send(input logic [63:0] frame, input int nBits);
    half();
    chipSelN = 1'h0;
    for (int i = 0; i < nBits; i++) begin
      serialDataIn = frame[63-i];
      half();
      spiClk = 1'h1;
      half();
      spiClk = 1'h0;
    end
    half();
    chipSelN = 1'h1;
    // released line flips so a stale bit never looks valid
    serialDataIn = ~serialDataIn;
  endtask
endmodule

/* File: test/test_flash_write_protect_ctrl.sv */
`timescale 1ns/1ps
module test_flash_write_protect_ctrl;
  import fwp_pkg::*;
  logic ref_clk, sys_rst, writeGuardN, mfPinIn, supplyLow, spiClk, chipSelN, serialDataIn;
  logic pauseActive, pinResetActive, mfPinIsData, highFreqQuad, writeEnableLatch;
  logic deviceBusy, deepSleep, writeLockout, opStart, cmdRejected, inv;
  logic [6:0] driveStrengthPct;
  logic [7:0] statusRegOne, statusRegTwo, statusRegThree, opCode, s, c;
  logic [20:0] a, m;
  logic [31:0] r;
  logic [31:0] seed = 32'h8D0F;
  fwp_range_type protRange, opTarget, er;
  int mismatches = 0;
  int testsRun = 0;
  int starts = 0;
  int rejects = 0;
  int busy = 0;
  int n0, nb;
  localparam logic [6:0] PCT [4] = '{7'h32, 7'h19, 7'h4B, 7'h64};
  fwp_ctrl #(.PUW_COUNT(400), .OP_COUNT(8)) fwp_ctrl_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .spiClk(spiClk), .chipSelN(chipSelN), .serialDataIn(serialDataIn), .writeGuardN(writeGuardN),
    .mfPinIn(mfPinIn), .supplyLow(supplyLow), .pauseActive(pauseActive),
    .pinResetActive(pinResetActive), .mfPinIsData(mfPinIsData), .driveStrengthPct(driveStrengthPct),
    .highFreqQuad(highFreqQuad), .writeEnableLatch(writeEnableLatch), .deviceBusy(deviceBusy),
    .deepSleep(deepSleep), .writeLockout(writeLockout), .statusRegOne(statusRegOne),
    .statusRegTwo(statusRegTwo), .statusRegThree(statusRegThree), .protRange(protRange),
    .opStart(opStart), .opCode(opCode), .opTarget(opTarget), .cmdRejected(cmdRejected));
  fwp_host fwp_host_inst (.ref_clk(ref_clk), .spiClk(spiClk), .chipSelN(chipSelN),
    .serialDataIn(serialDataIn));
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    starts <= starts + opStart;
    rejects <= rejects + cmdRejected;
    busy <= busy + deviceBusy;
  end
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic fwp_range_type expRange(input logic [7:0] s1);
    logic [21:0] size;
    fwp_range_type x;
    size = s1[6] ? (s1[4] ? 22'h8000 : 22'h1000 << (s1[4:2] - 3'h1))
                 : 22'h10000 << (s1[4:2] - 3'h1);
    if (s1[4:3] == 2'h3) size = 22'h200000;
    x.valid = (s1[4:2] != 3'h0);
    x.first = s1[5] ? 21'h0 : 21'(22'h200000 - size);
    x.last = s1[5] ? 21'(size - 22'h1) : 21'h1FFFFF;
    return x;
  endfunction
  function automatic logic hits(input fwp_range_type p, input logic iv, input logic [20:0] f,
    input logic [20:0] m);
    logic [20:0] l;
    l = f | m;
    if (iv) return !(p.valid && f >= p.first && l <= p.last);
    return p.valid && f <= p.last && l >= p.first;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic stopTest();
    $display("tests %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic frm(input logic [63:0] f, input int n);
    int k = 0;
    fwp_host_inst.send(f, n);
    repeat (8) @(posedge ref_clk);
    while (deviceBusy !== 1'h0 && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    if (k == 200) begin
      mismatches++;
      stopTest();
    end
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic wren();
    frm({OP_WREN, 56'h0}, 8);
  endtask
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    sys_rst = 1'h1;
    writeGuardN = 1'h1;
    mfPinIn = 1'h1;
    supplyLow = 1'h0;
    repeat (20) @(posedge ref_clk);
    #1;
    sys_rst = 1'h0;
    repeat (4) @(posedge ref_clk);
    #1;
    check(writeEnableLatch, 1'h0, "wel at power up");
    n0 = rejects;
    wren();
    check(rejects - n0, 1, "lockout refuse");
    check(writeEnableLatch, 1'h0, "wel in lockout");
    for (int k = 0; k < 600 && writeLockout !== 1'h0; k++) @(posedge ref_clk);
    check(writeLockout, 1'h0, "lockout end");
    if (writeLockout !== 1'h0) stopTest();
    $display("test lockout done");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      s = {i[2:0], r[0], 4'h0};
      wren();
      frm({OP_WSR3, s, 48'h0}, 16);
      check(driveStrengthPct, PCT[i[1:0]], "drive");
      check(highFreqQuad, r[0], "hf quad");
      check(statusRegThree, s, "sr3");
      mfPinIn = 1'h0;
      repeat (6) @(posedge ref_clk);
      #1;
      check({pauseActive, pinResetActive}, {~i[2], i[2]}, "pin role");
      mfPinIn = 1'h1;
      repeat (6) @(posedge ref_clk);
      #1;
    end
    wren();
    frm({OP_WSR2, 8'h02, 48'h0}, 16);
    mfPinIn = 1'h0;
    repeat (6) @(posedge ref_clk);
    #1;
    check({mfPinIsData, pauseActive, pinResetActive}, 3'h4, "quad pin");
    mfPinIn = 1'h1;
    wren();
    frm({OP_WSR2, 8'h00, 48'h0}, 16);
    $display("test pin done");
    wren();
    frm({OP_WSR1, 8'h80, 48'h0}, 16);
    writeGuardN = 1'h0;
    n0 = rejects;
    wren();
    frm({OP_WSR1, 8'h00, 48'h0}, 16);
    check(rejects - n0, 1, "guard lock");
    writeGuardN = 1'h1;
    wren();
    frm({OP_WSR1, 8'h00, 48'h0}, 16);
    check(statusRegOne[7], 1'h0, "guard open");
    frm({OP_WRDI, 56'h0}, 8);
    n0 = rejects;
    frm({OP_SECT, 56'h0}, 32);
    check(rejects - n0, 1, "no latch");
    n0 = rejects;
    frm({OP_WREN, 56'h0}, 9);
    check({rejects - n0, writeEnableLatch}, {32'h1, 1'h0}, "odd bits");
    frm({OP_SLEEP, 56'h0}, 8);
    wren();
    check({deepSleep, writeEnableLatch}, 2'h2, "sleep");
    frm({OP_WAKE, 56'h0}, 8);
    check(deepSleep, 1'h0, "wake");
    $display("test guard sleep done");
    for (int i = 0; i < 14; i++) begin
      r = rnd();
      s = {1'h0, r[6:2], 2'h0};
      inv = r[7];
      if (i < 8) s[4:2] = i[2:0];
      wren();
      frm({OP_WSR1, s, 1'h0, inv, 6'h0, 40'h0}, 24);
      check({statusRegOne[7:2], writeEnableLatch}, {s[7:2], 1'h0}, "sr write");
      check(statusRegTwo, {1'h0, inv, 6'h0}, "sr2");
      er = expRange(s);
      if (er.valid) check(protRange, er, "range");
      else check(protRange.valid, 1'h0, "no range");
      // random pick of page program, sector, block or chip erase
      m = r[31] ? (r[30] ? 21'h1FFFFF : 21'h0000FF) : (r[30] ? 21'h00FFFF : 21'h000FFF);
      c = r[31] ? (r[30] ? OP_CHIP_A : OP_PROG) : (r[30] ? OP_BLOCK : OP_SECT);
      a = (r[29] ? er.last : r[28:8]) & ~m;
      n0 = starts;
      nb = busy;
      wren();
      frm({c, 3'h0, a, 32'h0}, (r[31] && r[30]) ? 8 : r[31] ? 40 : 32);
      check(starts - n0, !hits(er, inv, a, m), "array op");
      check(busy - nb, 8 * (starts - n0), "busy time");
      if (starts != n0) check({opCode, opTarget}, {c, 1'h1, a, a | m}, "target");
    end
    $display("test protection done");
    supplyLow = 1'h1;
    repeat (4) @(posedge ref_clk);
    wren();
    check({writeLockout, writeEnableLatch}, 2'h2, "supply low");
    $display("test supply done");
    stopTest();
  end
endmodule
